// ===== shared/cgu_pkg.sv
// Constants and carrier types for the clock generator control block.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
`default_nettype none
package cgu_pkg;
  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_LOOP = 6'h38;
  localparam logic [5:0] IDX_REF = 6'h39;
  localparam logic [5:0] IDX_TEST = 6'h3a;
  localparam logic [5:0] IDX_FLAGS = 6'h3b;
  localparam logic [5:0] IDX_CTRL = 6'h3c;
  localparam logic [5:0] IDX_SEL = 6'h3d;
  localparam logic [5:0] IDX_SLOW = 6'h3e;
  localparam int ADDR_W = 8;
  // Flag register bits
  localparam int B_TOLIF = 7;
  localparam int B_LOCK = 6;
  localparam int B_LIMP_CHANGE_FLAG = 1;
  localparam int B_LIMP_ACTIVE = 0;
  // Control register bits
  localparam int B_TOLIE = 7;
  localparam int B_PWR = 6;
  localparam int B_AUTO = 5;
  localparam int B_NARROW = 4;
  localparam int B_OSC_RUN_IN_STOP = 2;
  localparam int B_LIMP_CHANGE_IRQ_EN = 1;
  localparam int B_NOLIMP = 0;
  // Clock select bits
  localparam int B_SYNTH = 6;
  localparam int B_DIV = 5;
  localparam int B_MOD = 2;
  // Control reset values by synthesizer supply level
  localparam logic [7:0] RST_CTRL_HI = 8'h60;
  localparam logic [7:0] RST_CTRL_LO = 8'h21;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // Cycles the system clock is held low across a source switch
  localparam logic [2:0] SWITCH_CYCLES = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Synchronised pin inputs
  localparam int S_REF = 0;
  localparam int S_TOL = 1;
  localparam int S_SUP = 2;
  localparam int S_TEST = 3;
  localparam int S_SPEC = 4;
  localparam int S_STOP = 5;
  localparam int NSYNC = 6;

  typedef enum logic [1:0] {SRC_OSC, SRC_SLOW, SRC_SYNTH} cgu_src_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } cgu_axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } cgu_axi_rsp_t;

  // One-cycle enables of the derived clock tree, plus the slow level
  typedef struct packed {
    logic system_clock;
    logic ext_bus_clock;
    logic periph_clock;
    logic aux_divided_clock;
    logic module_clock;
    logic debug_clock;
    logic divided_osc_clock;
  } cgu_clk_t;

  // Effective controls handed to the synthesizer
  typedef struct packed {
    logic power;
    logic narrow_bw;
    logic [5:0] loop_divide_count;
    logic [2:0] reference_divide_count;
  } cgu_synth_t;
endpackage
`default_nettype wire

// ===== src/cgu_clock_generator.sv
// Clock generator control: registers, limp-home, source select, dividers.
// Assumes the oscillator input runs at the clk rate, so every clk cycle is
// one oscillator tick, and the synthesizer output arrives as a one-cycle
// enable in the clk domain. Status pins come from outside and are synced.
`default_nettype none
module cgu_clock_generator
  import cgu_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire cgu_axi_req_t axi_req, // AXI4-Lite master signals
  output cgu_axi_rsp_t axi_rsp, // AXI4-Lite slave signals
  input wire logic synth_tick, // Synthesizer output enable
  input wire logic ref_clock_lost, // Pin: reference missing
  input wire logic synth_in_tolerance, // Pin: VCO within tolerance
  input wire logic synth_supply_level, // Pin: synth supply high
  input wire logic test_mode, // Pin: test mode
  input wire logic special_mode, // Pin: special mode
  input wire logic cpu_in_stop, // Pin: controller in stop
  output cgu_clk_t clk_out, // Derived clock enables
  output cgu_synth_t synth_ctrl, // Effective synthesizer controls
  output logic limp_active, // Limp-home in force
  output logic clock_monitor_reset, // One-cycle reset request
  output logic cpu_hold, // Processor stall during switch
  output logic osc_enable // Oscillator run enable
);

  // Three-stage synchronisers; a change counts once stages two and three agree
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sv;
  logic [2:0] sh_q [NSYNC];
  logic sv_q [NSYNC];
  assign pin_raw = {cpu_in_stop, special_mode, test_mode, synth_supply_level,
                    synth_in_tolerance, ref_clock_lost};
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    always_ff @(posedge clk) begin
      sh_q[i] <= {sh_q[i][1:0], pin_raw[i]};
      if (sh_q[i][1] == sh_q[i][2]) begin
        sv_q[i] <= sh_q[i][2];
      end
    end
    assign sv[i] = sv_q[i];
  end

  // Bus slave state
  logic aw_hold_q, w_hold_q, bvalid_q, awready_q, wready_q;
  logic arready_q, rvalid_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wlane_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  // Register fields
  logic [5:0] loop_q, slow_q;
  logic [2:0] ref_q;
  logic tolif_q, limp_change_flag_q, lock_prev_q, limp_q, ref_prev_q;
  logic tolie_q, pwr_q, auto_q, narrow_q, osc_run_in_stop_q, limp_change_irq_en_q, nolimp_q, nolimp_done_q;
  logic sel_synth_q, sel_div_q, mod_div_q;
  // Clock chain state
  cgu_src_t src_q;
  logic [2:0] sw_cnt_q;
  logic [5:0] sl_cnt_q;
  logic sl_lvl_q, bus_ph_q, aux_ph_q, osc_ph_q;
  cgu_clk_t clk_q;
  cgu_synth_t synth_q;
  logic cm_reset_q, hold_q, osc_en_q;

  // Write decode; strobes other than lane 0 touch nothing
  logic wr_en, aw_take, w_take, ar_take;
  logic [5:0] w_idx, r_idx;
  logic w_mapped, r_mapped;
  logic hit_loop, hit_ref, hit_flags, hit_ctrl, hit_sel, hit_slow;
  logic [7:0] wd;
  assign aw_take = axi_req.awvalid & awready_q;
  assign w_take = axi_req.wvalid & wready_q;
  assign ar_take = axi_req.arvalid & arready_q;
  assign wr_en = aw_hold_q & w_hold_q & ~bvalid_q;
  assign w_idx = awaddr_q[7:2];
  assign r_idx = axi_req.araddr[7:2];
  assign w_mapped = (awaddr_q[1:0] == 2'h0) & (w_idx >= IDX_LOOP) & (w_idx <= IDX_SLOW);
  assign r_mapped = (axi_req.araddr[1:0] == 2'h0) & (r_idx >= IDX_LOOP) &
                    (r_idx <= IDX_SLOW);
  assign wd = wdata_q;
  assign hit_loop = wr_en & wlane_q & (w_idx == IDX_LOOP) & w_mapped;
  assign hit_ref = wr_en & wlane_q & (w_idx == IDX_REF) & w_mapped;
  assign hit_flags = wr_en & wlane_q & (w_idx == IDX_FLAGS) & w_mapped;
  assign hit_ctrl = wr_en & wlane_q & (w_idx == IDX_CTRL) & w_mapped;
  assign hit_sel = wr_en & wlane_q & (w_idx == IDX_SEL) & w_mapped;
  assign hit_slow = wr_en & wlane_q & (w_idx == IDX_SLOW) & w_mapped;

  // Status and effective controls
  logic supply_lo, lock_stat, ref_lost, limp_d, bw_read;
  logic pwr_eff, synth_eff, mod_eff;
  assign supply_lo = ~sv[S_SUP];
  assign ref_lost = sv[S_REF];
  assign lock_stat = sv[S_TOL] & ~limp_q;
  assign limp_d = ref_lost & ~nolimp_q;
  assign bw_read = auto_q ? sv[S_TOL] : narrow_q;
  assign pwr_eff = pwr_q | limp_q;
  assign synth_eff = sel_synth_q | limp_q;
  assign mod_eff = mod_div_q & ~limp_q;

  // Flag next values; a set beats a same-cycle clear, limp beats both for TOLIF
  logic tolif_d, limp_change_flag_d;
  assign tolif_d = ~limp_q & ((lock_stat ^ lock_prev_q) |
                   (tolif_q & ~(hit_flags & wd[B_TOLIF])));
  assign limp_change_flag_d = (limp_d ^ limp_q) | (limp_change_flag_q & ~(hit_flags & wd[B_LIMP_CHANGE_FLAG]));

  // Readback images
  logic [7:0] rd_test, rd_flags, rd_ctrl, rd_sel, rd_mux;
  logic switching;
  assign rd_test = sv[S_TEST] ? {lock_stat, ref_lost, pwr_eff, synth_eff,
                   sel_div_q, mod_eff, sl_lvl_q, switching} : RST_ZERO;
  assign rd_flags = {tolif_q, lock_stat, 4'h0, limp_change_flag_q, limp_q};
  assign rd_ctrl = {tolie_q, pwr_q, auto_q, bw_read, 1'b0, osc_run_in_stop_q, limp_change_irq_en_q, nolimp_q};
  assign rd_sel = {1'b0, sel_synth_q, sel_div_q, 2'h0, mod_div_q, 2'h0};
  assign rd_mux = (r_idx == IDX_LOOP) ? {2'h0, loop_q} :
                  (r_idx == IDX_REF) ? {5'h00, ref_q} :
                  (r_idx == IDX_TEST) ? rd_test :
                  (r_idx == IDX_FLAGS) ? rd_flags :
                  (r_idx == IDX_CTRL) ? rd_ctrl :
                  (r_idx == IDX_SEL) ? rd_sel : {2'h0, slow_q};

  // Write channel: address and data taken in either order, one at a time
  logic aw_hold_d, w_hold_d, bvalid_d;
  assign aw_hold_d = (aw_hold_q & ~wr_en) | aw_take;
  assign w_hold_d = (w_hold_q & ~wr_en) | w_take;
  assign bvalid_d = wr_en | (bvalid_q & ~axi_req.bready);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= RST_ZERO;
      wlane_q <= 1'b0;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awready_q <= ~aw_hold_d;
      wready_q <= ~w_hold_d;
      bvalid_q <= bvalid_d;
      if (wr_en) begin
        bresp_q <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_take) begin
        awaddr_q <= axi_req.awaddr;
      end
      if (w_take) begin
        wdata_q <= axi_req.wdata[7:0];
        wlane_q <= axi_req.wstrb[0];
      end
    end
  end

  // Read channel: data registered at the address handshake
  logic rvalid_d;
  assign rvalid_d = ar_take | (rvalid_q & ~axi_req.rready);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      if (ar_take) begin
        rdata_q <= r_mapped ? {24'h00_0000, rd_mux} : 32'h0000_0000;
        rresp_q <= r_mapped ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end
  assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
                     bresp: bresp_q, arready: arready_q, rvalid: rvalid_q,
                     rdata: rdata_q, rresp: rresp_q};

  // Loop and reference counts are frozen while the synth select bit is set
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      loop_q <= '0;
      ref_q <= '0;
      slow_q <= '0;
    end else begin
      if (hit_loop & ~sel_synth_q) begin
        loop_q <= wd[5:0];
      end
      if (hit_ref & ~sel_synth_q) begin
        ref_q <= wd[2:0];
      end
      if (hit_slow) begin
        slow_q <= wd[5:0];
      end
    end
  end

  // Status flags and limp-home state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tolif_q <= 1'b0;
      limp_change_flag_q <= 1'b0;
      lock_prev_q <= 1'b0;
      limp_q <= 1'b0;
      ref_prev_q <= 1'b0;
      cm_reset_q <= 1'b0;
    end else begin
      tolif_q <= tolif_d;
      limp_change_flag_q <= limp_change_flag_d;
      lock_prev_q <= lock_stat;
      limp_q <= limp_d;
      ref_prev_q <= ref_lost;
      cm_reset_q <= ref_lost & ~ref_prev_q & nolimp_q;
    end
  end

  // Control register; reset image caught from the synced supply level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      {tolie_q, pwr_q, auto_q, narrow_q} <= supply_lo ? RST_CTRL_LO[7:4] :
                                                       RST_CTRL_HI[7:4];
      {osc_run_in_stop_q, limp_change_irq_en_q, nolimp_q} <= supply_lo ? RST_CTRL_LO[2:0] :
                                                RST_CTRL_HI[2:0];
      nolimp_done_q <= 1'b0;
    end else begin
      if (supply_lo) begin
        tolie_q <= 1'b0;
        pwr_q <= 1'b0;
        limp_change_irq_en_q <= 1'b0;
        nolimp_q <= 1'b1;
      end else if (hit_ctrl) begin
        tolie_q <= wd[B_TOLIE];
        pwr_q <= wd[B_PWR] | sel_synth_q;
        limp_change_irq_en_q <= wd[B_LIMP_CHANGE_IRQ_EN];
        if (sv[S_SPEC] | ~nolimp_done_q) begin
          nolimp_q <= wd[B_NOLIMP];
        end
      end
      if (hit_ctrl) begin
        auto_q <= wd[B_AUTO];
        osc_run_in_stop_q <= wd[B_OSC_RUN_IN_STOP];
        nolimp_done_q <= 1'b1;
        if (!auto_q) begin
          narrow_q <= wd[B_NARROW];
        end
      end
    end
  end

  // Clock select register; synth select needs power on
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel_synth_q <= 1'b0;
      sel_div_q <= 1'b0;
      mod_div_q <= 1'b0;
    end else if (hit_sel) begin
      sel_synth_q <= wd[B_SYNTH] & pwr_q;
      sel_div_q <= wd[B_DIV];
      mod_div_q <= wd[B_MOD];
    end
  end

  // Source wanted versus source in use; a mismatch opens a switch window
  cgu_src_t src_want;
  assign src_want = synth_eff ? SRC_SYNTH : (sel_div_q ? SRC_SLOW : SRC_OSC);
  assign switching = (src_want != src_q);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_q <= SRC_OSC;
      sw_cnt_q <= '0;
    end else if (switching) begin
      if (sw_cnt_q == SWITCH_CYCLES - 3'h1) begin
        src_q <= src_want;
        sw_cnt_q <= '0;
      end else begin
        sw_cnt_q <= sw_cnt_q + 3'h1;
      end
    end else begin
      sw_cnt_q <= '0;
    end
  end

  // Slow divider: level toggles every divider value ticks, so 2N period
  logic sl_byp, sl_wrap, slow_tick;
  assign sl_byp = (slow_q == 6'h00);
  assign sl_wrap = (sl_cnt_q + 6'h01 == slow_q);
  assign slow_tick = sl_byp | (sl_wrap & ~sl_lvl_q);
  always_ff @(posedge clk) begin
    if (!rst_n || hit_slow) begin
      // Restart on write so the new ratio shows within one slow period
      sl_cnt_q <= '0;
      sl_lvl_q <= 1'b0;
    end else if (sl_byp || sl_wrap) begin
      sl_cnt_q <= '0;
      sl_lvl_q <= ~sl_lvl_q;
    end else begin
      sl_cnt_q <= sl_cnt_q + 6'h01;
    end
  end

  // System tick from the source in use, silent while switching
  logic sys_tick, bus_tick, aux_src, aux_tick, dbg_tick, mod_tick;
  always_comb begin
    sys_tick = 1'b0;
    case (src_q)
      SRC_OSC: sys_tick = 1'b1;
      SRC_SLOW: sys_tick = slow_tick;
      SRC_SYNTH: sys_tick = synth_tick;
      default: sys_tick = 1'b0;
    endcase
    if (switching) begin
      sys_tick = 1'b0;
    end
  end
  assign bus_tick = sys_tick & bus_ph_q;
  assign aux_src = limp_q ? synth_tick : slow_tick;
  assign aux_tick = aux_src & aux_ph_q;
  assign dbg_tick = limp_q ? aux_tick :
                    (sel_div_q & ~sel_synth_q & ~sl_byp) ? bus_tick : osc_ph_q;
  assign mod_tick = mod_eff ? aux_tick : bus_tick;

  // Halving phases and registered outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_ph_q <= 1'b0;
      aux_ph_q <= 1'b0;
      osc_ph_q <= 1'b0;
      clk_q <= '0;
      synth_q <= '0;
      hold_q <= 1'b0;
      osc_en_q <= 1'b1;
    end else begin
      bus_ph_q <= bus_ph_q ^ sys_tick;
      aux_ph_q <= aux_ph_q ^ aux_src;
      osc_ph_q <= ~osc_ph_q;
      clk_q <= '{system_clock: sys_tick, ext_bus_clock: bus_tick,
                 periph_clock: bus_tick, aux_divided_clock: aux_tick,
                 module_clock: mod_tick, debug_clock: dbg_tick,
                 divided_osc_clock: sl_lvl_q};
      synth_q <= '{power: pwr_eff, narrow_bw: bw_read, loop_divide_count: loop_q,
                   reference_divide_count: ref_q};
      hold_q <= switching;
      osc_en_q <= ~sv[S_STOP] | osc_run_in_stop_q;
    end
  end

  assign clk_out = clk_q;
  assign synth_ctrl = synth_q;
  assign limp_active = limp_q;
  assign clock_monitor_reset = cm_reset_q;
  assign cpu_hold = hold_q;
  assign osc_enable = osc_en_q;

endmodule
`default_nettype wire

// ===== test/cgu_clock_generator_sva.sv
// Port assertions for the clock generator control block.
// Bound into every cgu_clock_generator; one clk domain, sync reset.
`default_nettype none
module cgu_clock_generator_sva
  import cgu_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Sync reset, active low
  input wire cgu_axi_req_t axi_req, // Bus request
  input wire cgu_axi_rsp_t axi_rsp, // Bus response
  input wire logic test_mode, // Test mode pin
  input wire cgu_clk_t clk_out, // Clock enables
  input wire cgu_synth_t synth_ctrl, // Synth controls
  input wire logic limp_active, // Limp-home status
  input wire logic clock_monitor_reset, // Monitor reset pulse
  input wire logic cpu_hold // Switch stall
);
  logic [5:0] ridx_q;
  // Index of the read in flight, since rdata does not carry it
  always_ff @(posedge clk) begin
    if (axi_req.arvalid && axi_rsp.arready) begin
      ridx_q <= axi_req.araddr[7:2];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Steps of a source switch: frozen window, then release
  sequence s_frozen;
    cpu_hold && !clk_out.system_clock;
  endsequence
  sequence s_switch;
    s_frozen [*4] ##1 !cpu_hold;
  endsequence
  a_switch_hold: assert property ($rose(cpu_hold) |-> s_switch)
    else $error("source switch window wrong");
  a_test_zero: assert property ($rose(axi_rsp.rvalid) && ridx_q == IDX_TEST && !test_mode
    |-> axi_rsp.rdata == 32'h0000_0000) else $error("test readout not zero");
  a_limp_lock: assert property ($rose(axi_rsp.rvalid) && ridx_q == IDX_FLAGS
    && limp_active && $past(limp_active, 2) |-> !axi_rsp.rdata[B_LOCK] && !axi_rsp.rdata[B_TOLIF])
    else $error("lock bits set in limp-home");
  a_limp_power: assert property (limp_active && $past(limp_active) |-> synth_ctrl.power)
    else $error("synth power not forced in limp-home");
  a_bus_periph: assert property (clk_out.ext_bus_clock == clk_out.periph_clock)
    else $error("bus and peripheral ticks differ");
  a_bus_sys: assert property (!limp_active && clk_out.ext_bus_clock |-> clk_out.system_clock)
    else $error("bus tick without system tick");
  a_bus_spaced: assert property (clk_out.ext_bus_clock |=> !clk_out.ext_bus_clock)
    else $error("bus ticks back to back");
  a_aux_spaced: assert property (clk_out.aux_divided_clock |=> !clk_out.aux_divided_clock)
    else $error("aux ticks back to back");
  // Debug source hops on limp change or a source switch may give one short gap
  a_debug_spaced: assert property (clk_out.debug_clock && !$changed(limp_active)
    |=> !clk_out.debug_clock || $rose(cpu_hold)) else $error("debug ticks back to back");
  a_cm_pulse: assert property (clock_monitor_reset |-> !limp_active ##1 !clock_monitor_reset)
    else $error("monitor reset not a lone pulse");
endmodule
bind cgu_clock_generator cgu_clock_generator_sva i_sva (.clk(clk), .rst_n(rst_n),
  .axi_req(axi_req), .axi_rsp(axi_rsp), .test_mode(test_mode), .clk_out(clk_out),
  .synth_ctrl(synth_ctrl), .limp_active(limp_active),
  .clock_monitor_reset(clock_monitor_reset), .cpu_hold(cpu_hold));
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the clock generator control block.
// Drives AXI4-Lite and status pins itself; clk is 100 MHz.
`default_nettype none
module tb
  import cgu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, tick, lost, tol, sup, tmode, spec, stop, limp, cmr, hold, osc;
  cgu_axi_req_t req;
  cgu_axi_rsp_t rsp;
  cgu_clk_t co;
  cgu_synth_t sc;
  logic [31:0] seed, d;
  logic [31:0] tseed = 32'h4f6b_e2cd;
  logic [1:0] r;
  int fails, compares, nd, g, i, m_loop;
  int tsel[9] = '{0, 0, 0, 0, 32, 32, 32, 36, 0};
  int tbit[9] = '{0, 3, 4, 1, 6, 5, 1, 2, 2};
  int tmul[9] = '{2, 4, 0, 0, 2, 4, 4, 4, 0};
  int tadd[9] = '{0, 0, 2, 2, 0, 0, 0, 0, 2};
  cgu_clock_generator i_cgu_clock_generator (.clk(clk), .rst_n(rst_n), .axi_req(req),
    .axi_rsp(rsp), .synth_tick(tick), .ref_clock_lost(lost), .synth_in_tolerance(tol),
    .synth_supply_level(sup), .test_mode(tmode), .special_mode(spec), .cpu_in_stop(stop),
    .clk_out(co), .synth_ctrl(sc), .limp_active(limp), .clock_monitor_reset(cmr),
    .cpu_hold(hold), .osc_enable(osc));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random synthesizer ticks; a separate stream keeps the main sequence repeatable
  always @(posedge clk) begin
    tseed <= lfsr(tseed);
    tick <= tseed[3];
  end
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic to_chk(input bit bad);
    if (bad) begin
      fails++;
      stop_test();
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [5:0] idx, input logic [7:0] v);
    int n;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= {idx, 2'b00};
    req.wvalid <= 1'b1;
    req.wdata <= {24'h00_0000, v};
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid) break;
    end
    req.bready <= 1'b0;
    to_chk(n >= 200);
  endtask
  task automatic rd(input logic [5:0] idx, output logic [31:0] v, output logic [1:0] rr);
    int n;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= {idx, 2'b00};
    req.rready <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge clk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid) break;
    end
    v = rsp.rdata;
    rr = rsp.rresp;
    req.rready <= 1'b0;
    to_chk(n >= 200);
  endtask
  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    rd(idx, d, r);
    chk(d, exp);
  endtask
  // Cycles between two rising edges of one clock enable
  task automatic gap(input int k, output int gg);
    int n, rises;
    logic p;
    p = 1'b1;
    rises = 0;
    gg = 0;
    for (n = 0; n < 400 && rises < 2; n++) begin
      @(posedge clk);
      if (rises == 1) gg++;
      if (co[k] && !p) rises++;
      p = co[k];
    end
    to_chk(rises < 2);
  endtask
  initial begin
    {rst_n, lost, tol, tmode, spec, stop} = 6'h00;
    sup = 1'b1;
    req = '0;
    seed = 32'h4f6b_e2cd;
    fails = 0;
    compares = 0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(2);
    for (i = 0; i < 7; i++) begin
      rdchk(IDX_LOOP + 6'(i), (i == 4) ? 32'h0000_0060 : 32'h0);
    end
    // Unmapped index: error response and zero data
    rd(6'h10, d, r);
    chk(d, 32'h0000_0000);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    seed = lfsr(seed);
    m_loop = int'(seed[5:0]);
    wr(IDX_LOOP, seed[7:0]);
    rdchk(IDX_LOOP, 32'(m_loop));
    wr(IDX_REF, seed[15:8]);
    rdchk(IDX_REF, {29'h0, seed[10:8]});
    wr(IDX_TEST, 8'hff);
    rdchk(IDX_TEST, 32'h0);
    // Divider chain, random ratio 1 to 7
    nd = int'(seed[23:16] % 8'h07) + 1;
    wr(IDX_SLOW, 8'(nd));
    for (i = 0; i < 9; i++) begin
      wr(IDX_SEL, 8'(tsel[i]));
      cyc(10);
      gap(tbit[i], g);
      chk(32'(g), 32'(tmul[i] * nd + tadd[i]));
    end
    wr(IDX_SLOW, 8'h00);
    gap(3, g);
    chk(32'(g), 32'h2);
    // Synth select refused with power off, then locked-out writes
    wr(IDX_CTRL, 8'h20);
    wr(IDX_SEL, 8'h40);
    rdchk(IDX_SEL, 32'h0);
    wr(IDX_CTRL, 8'h60);
    wr(IDX_SEL, 8'h40);
    rdchk(IDX_SEL, 32'h40);
    wr(IDX_LOOP, 8'h15);
    rdchk(IDX_LOOP, 32'(m_loop));
    chk(32'(sc.loop_divide_count), 32'(m_loop));
    wr(IDX_REF, 8'h05);
    rdchk(IDX_REF, {29'h0, seed[10:8]});
    wr(IDX_CTRL, 8'h20);
    rdchk(IDX_CTRL, 32'h60);
    // Test mode image; slow level bit masked, it toggles every cycle in bypass
    tmode <= 1'b1;
    cyc(8);
    rd(IDX_TEST, d, r);
    chk(d & 32'h0000_00fd, 32'h0000_0030);
    tmode <= 1'b0;
    cyc(8);
    // Lock change in both directions
    tol <= 1'b1;
    cyc(8);
    rdchk(IDX_FLAGS, 32'hc0);
    rdchk(IDX_CTRL, 32'h70);
    wr(IDX_FLAGS, 8'hc0);
    rdchk(IDX_FLAGS, 32'h40);
    tol <= 1'b0;
    cyc(8);
    rdchk(IDX_FLAGS, 32'h80);
    tol <= 1'b1;
    cyc(8);
    wr(IDX_FLAGS, 8'h80);
    wr(IDX_CTRL, 8'h61);
    rdchk(IDX_CTRL, 32'h70);
    // Reference loss enters limp-home
    lost <= 1'b1;
    cyc(8);
    chk(32'(limp), 32'h1);
    rdchk(IDX_FLAGS, 32'h03);
    wr(IDX_FLAGS, 8'h02);
    rdchk(IDX_FLAGS, 32'h01);
    lost <= 1'b0;
    cyc(8);
    rdchk(IDX_FLAGS, 32'hc2);
    // Special mode: limp-disable writable, loss gives monitor reset
    spec <= 1'b1;
    cyc(8);
    wr(IDX_CTRL, 8'h61);
    rdchk(IDX_CTRL, 32'h71);
    lost <= 1'b1;
    for (i = 0; i < 50 && cmr !== 1'b1; i++) @(posedge clk);
    chk({31'h0, cmr}, 32'h1);
    cyc(4);
    chk({31'h0, limp}, 32'h0);
    // Let the synced loss clear before limp-disable is written low
    lost <= 1'b0;
    cyc(8);
    // Auto off first; the narrow bit is writable only once auto is clear
    wr(IDX_CTRL, 8'h40);
    wr(IDX_CTRL, 8'h50);
    cyc(2);
    chk({31'h0, sc.narrow_bw}, 32'h1);
    stop <= 1'b1;
    wr(IDX_CTRL, 8'h44);
    cyc(8);
    chk({30'h0, sc.narrow_bw, osc}, 32'h1);
    wr(IDX_CTRL, 8'h40);
    cyc(4);
    chk({31'h0, osc}, 32'h0);
    stop <= 1'b0;
    // Second reset with the synthesizer supply low, tolerance lost
    rst_n <= 1'b0;
    sup <= 1'b0;
    tol <= 1'b0;
    cyc(10);
    rst_n <= 1'b1;
    cyc(2);
    rdchk(IDX_CTRL, 32'h21);
    wr(IDX_CTRL, 8'hc2);
    rdchk(IDX_CTRL, 32'h01);
    stop_test();
  end
endmodule
`default_nettype wire
